// *** hw/kbd_consts.vh ***
/*
  shared constants of the keyboard matrix encoder: matrix size, debounce
  times, clock period and code bases.
  assumes inclusion by bare name from the design files under hw/.
*/
`ifndef KBD_CONSTS_VH
`define KBD_CONSTS_VH

// ----------------------------------------------------------------------
// matrix geometry
// ----------------------------------------------------------------------
`define DRIVE_COUNT        11
`define SENSE_COUNT        8
`define LAST_DRIVE         4'ha
`define LAST_SENSE         3'h7
`define FIRST_HEX_DRIVE    4'h7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      40
`define CLOSE_DEBOUNCE_NS  1000000
`define RELEASE_DEBOUNCE_NS 5000000

// ----------------------------------------------------------------------
// code bases
// ----------------------------------------------------------------------
`define HEX_CODE_BASE      8'h80
`define DIGIT_BASE         8'h30
`define PUNCT_BASE         8'h28
`define UPPER_BASE         8'h40
`define LOWER_BASE         8'h60
`define SHIFT_FLIP         8'h10
`define CODE_SPACE         8'h20
`define CODE_LINE_FEED     8'h0a
`define CODE_ESCAPE        8'h1b
`define CODE_CR            8'h0d
`define CODE_DELETE        8'h7f

`endif

// *** hw/key_code_map.v ***
/*
  combinational map from a matrix position and the modifier levels to an
  eight-bit key code, with a flag for positions that give no response.
  assumes drive index 0..10 and sense index 0..7 from the scan counters.
*/
`timescale 1ns/1ps
`include "kbd_consts.vh"

module key_code_map (
  // position
  input  wire [3:0] drive_idx,
  input  wire [2:0] sense_idx,
  // modifiers
  input  wire       ctrl,
  input  wire       shift,
  input  wire       alpha,
  // result
  output reg  [7:0] code,
  output reg        valid
);

  reg [7:0] letter;
  reg [7:0] normal;

  always @* begin
    code   = 8'h00;
    valid  = 1'b1;
    letter = {3'h0, drive_idx[1:0] - 2'h2, sense_idx};
    normal = 8'h00;
    if (drive_idx >= `FIRST_HEX_DRIVE) begin
      // hex keys ignore every modifier
      code = `HEX_CODE_BASE + {1'b0, drive_idx - `FIRST_HEX_DRIVE, sense_idx};
    end else if (drive_idx <= 4'h1) begin
      if (drive_idx == 4'h0)
        normal = `DIGIT_BASE + {5'h00, sense_idx};
      else if (sense_idx < 3'h4)
        normal = `DIGIT_BASE + 8'h08 + {5'h00, sense_idx};
      else
        normal = `PUNCT_BASE + {5'h00, sense_idx};
      if (ctrl)
        valid = 1'b0;
      else if (shift)
        code = normal ^ `SHIFT_FLIP;
      else
        code = normal;
    end else if (drive_idx <= 4'h5) begin
      letter = {3'h0, drive_idx[1:0] - 2'h2, sense_idx};
      if (ctrl)
        code = letter;
      else if (shift)
        code = `UPPER_BASE + letter;
      else if (alpha && letter != 8'h00 && letter < 8'h1b)
        code = `UPPER_BASE + letter;
      else
        code = `LOWER_BASE + letter;
    end else begin
      case (sense_idx)
        3'h0: code = `CODE_SPACE;
        3'h2: code = `CODE_LINE_FEED;
        3'h3: code = `CODE_ESCAPE;
        3'h5: code = `CODE_CR;
        3'h7: code = `CODE_DELETE;
        default: valid = 1'b0;
      endcase
    end
  end

endmodule // key_code_map

// *** hw/keyboard_matrix_encoder.v ***
/*
  keyboard matrix encoder: scans an 11 x 8 switch matrix, debounces the
  first closed key, and offers its code on a three-state bus with ready
  and repeat flags for a small processor.
  assumes the processor timing pulse is far slower than mclk (at least
  eight mclk periods each phase) so the matrix settles before sampling.
*/
// How it works
// - eleven drive outputs across eight sense inputs
// - sense high means closed on driven line
// - chip selects enable bus and ready clear
// - selected bus presents the held key code
// - ready flag drops low on valid closure
// - ready rises on pulse edge during read
// - timing pulse steps scan, and clears ready during a read
// - repeat low after read while key held
// - release counts valid only after debounce delay
// - shift and control latched after debounce
// - modifiers alone never make a code
// - alpha lock is a live level
// - control over shift over alpha priority
// - drive lines eight to eleven give hex
// - valid keydown freezes the scan counters
// - ready stays high until new closure
// - first key in scan order locks others
// - repeat rises when release debounce ends
`timescale 1ns/1ps
`include "kbd_consts.vh"

module keyboard_matrix_encoder #(
  parameter [3:0] CS_ACTIVE          = 4'hf,
  parameter       CLOSE_DB_CYCLES    = (`CLOSE_DEBOUNCE_NS + `CLK_PERIOD_NS - 1)
                                       / `CLK_PERIOD_NS,
  parameter       RELEASE_DB_CYCLES  = (`RELEASE_DEBOUNCE_NS + `CLK_PERIOD_NS - 1)
                                       / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // matrix
  output reg  [10:0] drive_lines,
  input  wire [7:0]  sense_lines,
  // modifiers
  input  wire        shift_key,
  input  wire        control_key,
  input  wire        alpha_lock,
  // processor side
  input  wire        timing_pulse,
  input  wire        chip_select_a,
  input  wire        chip_select_b,
  input  wire        chip_select_c,
  input  wire        chip_select_d,
  output reg  [7:0]  bus_out,
  output wire [7:0]  bus_oe,
  output reg         key_ready_n,
  output reg         key_held_n
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam [2:0] ST_SCAN       = 3'h0;
  localparam [2:0] ST_CLOSE_DB   = 3'h1;
  localparam [2:0] ST_HELD       = 3'h2;
  localparam [2:0] ST_RELEASE_DB = 3'h3;
  localparam [2:0] ST_WAIT_READ  = 3'h4;

  // counts are compared on a 24-bit counter, so cut the integer on purpose
  localparam integer CLOSE_LAST_INT   = CLOSE_DB_CYCLES - 1;
  localparam integer RELEASE_LAST_INT = RELEASE_DB_CYCLES - 1;
  localparam [23:0]  CLOSE_LAST       = CLOSE_LAST_INT[23:0];
  localparam [23:0]  RELEASE_LAST     = RELEASE_LAST_INT[23:0];

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // all inputs are pins: three flops, a bit changes once stages two and
  // three agree, which also rejects single-cycle glitches
  wire [15:0] pins = {timing_pulse, chip_select_d, chip_select_c, chip_select_b,
                      chip_select_a, alpha_lock, control_key, shift_key, sense_lines};
  reg  [15:0] sync1;
  reg  [15:0] sync2;
  reg  [15:0] sync3;
  reg  [15:0] filt;
  reg         tp_prev;

  always @(posedge mclk) begin
    if (!rst_n) begin
      sync1   <= 16'h0000;
      sync2   <= 16'h0000;
      sync3   <= 16'h0000;
      filt    <= 16'h0000;
      tp_prev <= 1'b0;
    end else begin
      sync1   <= pins;
      sync2   <= sync1;
      sync3   <= sync2;
      filt    <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
      tp_prev <= filt[15];
    end
  end

  wire [7:0] sense    = filt[7:0];
  wire       shift_in = filt[8];
  wire       ctrl_in  = filt[9];
  wire       alpha_in = filt[10];
  wire [3:0] cs_in    = filt[14:11];
  wire       tp_rise  = filt[15] & ~tp_prev;

  // all four selects at their active level make a read cycle
  wire read_sel = &(cs_in ~^ CS_ACTIVE);

  // ----------------------------------------------------------------------
  // scan counters and code map
  // ----------------------------------------------------------------------
  reg  [3:0]  drive_idx;
  reg  [2:0]  sense_idx;
  reg  [2:0]  state;
  reg  [23:0] db_count;
  reg         shift_latch;
  reg         ctrl_latch;
  reg         read_done;
  wire        hit = sense[sense_idx];

  wire [7:0]  scan_code;
  wire        scan_valid;
  wire [7:0]  held_code;
  wire        held_valid;

  // live modifiers decide whether a key is worth a response at all
  key_code_map u_scan_map (
    .drive_idx (drive_idx),
    .sense_idx (sense_idx),
    .ctrl      (ctrl_in),
    .shift     (shift_in),
    .alpha     (alpha_in),
    .code      (scan_code),
    .valid     (scan_valid)
  );

  // latched shift/control and live alpha shape the presented code
  key_code_map u_held_map (
    .drive_idx (drive_idx),
    .sense_idx (sense_idx),
    .ctrl      (ctrl_latch),
    .shift     (shift_latch),
    .alpha     (alpha_in),
    .code      (held_code),
    .valid     (held_valid)
  );

  // ----------------------------------------------------------------------
  // control state machine
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      state       <= ST_SCAN;
      drive_idx   <= 4'h0;
      sense_idx   <= 3'h0;
      db_count    <= 24'h000000;
      shift_latch <= 1'b0;
      ctrl_latch  <= 1'b0;
      read_done   <= 1'b0;
      key_ready_n <= 1'b1;
      key_held_n  <= 1'b1;
      bus_out     <= 8'h00;
      drive_lines <= 11'h001;
    end else begin
      drive_lines <= 11'h001 << drive_idx;
      // ready clears on a read edge; a set below in the same cycle wins
      if (tp_rise && read_sel && !key_ready_n) begin
        key_ready_n <= 1'b1;
        read_done   <= 1'b1;
      end
      case (state)
        ST_SCAN: begin
          db_count <= 24'h000000;
          if (tp_rise) begin
            if (hit && scan_valid) begin
              state <= ST_CLOSE_DB;
            end else if (sense_idx == `LAST_SENSE) begin
              sense_idx <= 3'h0;
              drive_idx <= (drive_idx == `LAST_DRIVE) ? 4'h0 : drive_idx + 4'h1;
            end else begin
              sense_idx <= sense_idx + 3'h1;
            end
          end
        end
        ST_CLOSE_DB: begin
          // bounce back to scanning if the contact drops early
          if (!hit) begin
            state <= ST_SCAN;
          end else if (db_count == CLOSE_LAST) begin
            state       <= ST_HELD;
            shift_latch <= shift_in;
            ctrl_latch  <= ctrl_in;
            key_ready_n <= 1'b0;
            read_done   <= 1'b0;
            db_count    <= 24'h000000;
          end else begin
            db_count <= db_count + 24'h000001;
          end
        end
        ST_HELD: begin
          db_count <= 24'h000000;
          if (!hit)
            state <= ST_RELEASE_DB;
          else if (read_done && key_ready_n)
            key_held_n <= 1'b0;
        end
        ST_RELEASE_DB: begin
          if (hit) begin
            state <= ST_HELD;
          end else if (db_count == RELEASE_LAST) begin
            key_held_n <= 1'b1;
            state      <= (read_done || (tp_rise && read_sel)) ? ST_SCAN : ST_WAIT_READ;
          end else begin
            db_count <= db_count + 24'h000001;
          end
        end
        ST_WAIT_READ: begin
          // released but unread: the lockout stays until the read
          if (read_done)
            state <= ST_SCAN;
        end
        default: state <= ST_SCAN;
      endcase
      // code follows the frozen position; modifiers alone never reach here
      if (state != ST_SCAN && held_valid)
        bus_out <= held_code;
    end
  end

  // ----------------------------------------------------------------------
  // three-state bus enable
  // ----------------------------------------------------------------------
  assign bus_oe = {8{read_sel}};

endmodule // keyboard_matrix_encoder

// *** bench/kbd_matrix_model.sv ***
/*
  switch matrix model: closed keys join a drive line to a sense line.
  assumes keys[d*8+s] is set by the bench for drive d, sense s.
*/
`timescale 1ns/1ps
module kbd_matrix_model (
  // matrix
  input  wire logic [10:0] drive_lines,
  input  wire logic [87:0] keys,
  output logic      [7:0]  sense_lines
);
  // open switches leave a sense line at its pull-down level
  always_comb begin
    sense_lines = 8'h00;
    for (int d = 0; d < 11; d++)
      for (int s = 0; s < 8; s++)
        if (keys[d*8+s] && drive_lines[d]) sense_lines[s] = 1'b1;
  end
endmodule // kbd_matrix_model

// *** bench/kbd_enc_chk.sv ***
/*
  port checker of the keyboard matrix encoder.
  assumes one clock, mclk, and synchronous active-low rst_n.
*/
`timescale 1ns/1ps
module kbd_enc_chk (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // outputs watched
  input wire logic [10:0] drive_lines,
  input wire logic [7:0]  bus_out,
  input wire logic [7:0]  bus_oe,
  input wire logic        key_ready_n,
  input wire logic        key_held_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_drive_one_hot: assert property ($onehot(drive_lines))
    else $error("drive lines not one-hot");
  chk_oe_whole_bus: assert property (bus_oe == 8'h00 || bus_oe == 8'hff)
    else $error("bus enable split");
  chk_ready_clear_read: assert property ($rose(key_ready_n) |-> $past(bus_oe) == 8'hff)
    else $error("ready cleared without read");
  chk_held_needs_ready: assert property (!key_held_n |-> key_ready_n)
    else $error("repeat low while ready low");
  chk_held_after_read: assert property ($fell(key_held_n) |-> $past(key_ready_n))
    else $error("repeat fell before read");
  chk_scan_frozen: assert property (!key_ready_n |-> $stable(drive_lines))
    else $error("scan moved while ready");
  chk_freeze_holds: assert property ($fell(key_ready_n) |=> $stable(drive_lines) [*4])
    else $error("scan left frozen key");
  chk_hex_code: assert property (!key_ready_n && $past(!key_ready_n)
    && drive_lines[10:7] != 0 |-> bus_out[7:5] == 3'h4)
    else $error("hex key code out of range");
  chk_ascii_code: assert property (!key_ready_n && $past(!key_ready_n)
    && drive_lines[6:0] != 0 |-> !bus_out[7])
    else $error("ascii key code top bit set");
  cover property ($fell(key_ready_n));
  cover property ($fell(key_held_n));
  cover property ($rose(key_held_n));
endmodule // kbd_enc_chk

bind keyboard_matrix_encoder kbd_enc_chk u_kbd_enc_chk (.mclk(mclk), .rst_n(rst_n),
  .drive_lines(drive_lines), .bus_out(bus_out), .bus_oe(bus_oe),
  .key_ready_n(key_ready_n), .key_held_n(key_held_n));

// *** bench/test_keyboard_matrix_encoder.sv ***
/*
  self-checking bench of the keyboard matrix encoder.
  assumes short debounce counts (4 and 8) and a timing pulse of 16 mclk.
*/
`timescale 1ns/1ps
module test_keyboard_matrix_encoder;
  logic        mclk = 0, rst_n = 0, timing_pulse = 0;
  logic        shift_key = 0, control_key = 0, alpha_lock = 0;
  logic [3:0]  sel = 4'h0;
  logic [87:0] keys = '0;
  logic [10:0] drive_lines;
  logic [7:0]  sense_lines, bus_out, bus_oe;
  logic        key_ready_n, key_held_n;
  integer      errors = 0, total_checks = 0;
  always #20 mclk = ~mclk;
  // phases of 8 mclk keep the sync filter well inside each half
  always begin repeat (8) @(negedge mclk); timing_pulse = ~timing_pulse; end
  keyboard_matrix_encoder #(.CS_ACTIVE(4'hf), .CLOSE_DB_CYCLES(4), .RELEASE_DB_CYCLES(8))
    u_keyboard_matrix_encoder (.mclk(mclk), .rst_n(rst_n), .drive_lines(drive_lines),
    .sense_lines(sense_lines), .shift_key(shift_key), .control_key(control_key),
    .alpha_lock(alpha_lock), .timing_pulse(timing_pulse), .chip_select_a(sel[0]),
    .chip_select_b(sel[1]), .chip_select_c(sel[2]), .chip_select_d(sel[3]),
    .bus_out(bus_out), .bus_oe(bus_oe), .key_ready_n(key_ready_n), .key_held_n(key_held_n));
  kbd_matrix_model u_kbd_matrix_model (.drive_lines(drive_lines), .keys(keys),
    .sense_lines(sense_lines));
  task conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check_code(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin errors++; $display("Error %0t code %h not %h", $time, got, exp); end
  endtask
  task check_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin errors++; $display("Error %0t flag %b not %b", $time, got, exp); end
  endtask
  // bounded wait; a flag that never comes fails the next compare
  task wait_flag(input logic held, input logic v);
    for (int n = 0; n < 3000 && (held ? key_held_n : key_ready_n) !== v; n++) @(negedge mclk);
  endtask
  task read_key(input logic held);
    sel = 4'hf;
    wait_flag(0, 1'b1);
    check_code(bus_oe, 8'hff);
    repeat (3) @(negedge mclk);
    check_flag(key_held_n, ~held);
    sel = 4'h0;
    repeat (6) @(negedge mclk);
    check_code(bus_oe, 8'h00);
  endtask
  task key_case(input int idx, input logic c, sh, al, input logic [7:0] exp);
    {control_key, shift_key, alpha_lock} = {c, sh, al};
    repeat (8) @(negedge mclk);
    keys[idx] = 1'b1;
    wait_flag(0, 1'b0);
    check_flag(drive_lines[idx/8], 1'b1);
    @(negedge mclk);
    check_code(bus_out, exp);
    read_key(1'b1);
    keys[idx] = 1'b0;
    wait_flag(1, 1'b1);
    check_flag(key_held_n, 1'b1);
    {control_key, shift_key, alpha_lock} = 3'h0;
    // let an edge pass so the next case never re-raises a level in this step
    @(negedge mclk);
  endtask
  // a release shorter than the release debounce must not end the hold
  task bounce;
    keys[40] = 1'b1;
    wait_flag(0, 1'b0);
    @(negedge mclk);
    check_code(bus_out, 8'h78);
    read_key(1'b1);
    keys[40] = 1'b0;
    repeat (3) @(negedge mclk);
    keys[40] = 1'b1;
    repeat (20) @(negedge mclk);
    check_flag(key_held_n, 1'b0);
    keys[40] = 1'b0;
    wait_flag(1, 1'b1);
    check_flag(key_held_n, 1'b1);
  endtask
  task lockout;
    keys[32] = 1'b1;
    wait_flag(0, 1'b0);
    keys[9] = 1'b1;
    @(negedge mclk);
    check_code(bus_out, 8'h70);
    read_key(1'b1);
    repeat (200) @(negedge mclk);
    check_flag(key_ready_n, 1'b1);
    keys[32] = 1'b0;
    wait_flag(0, 1'b0);
    @(negedge mclk);
    check_code(bus_out, 8'h39);
    read_key(1'b1);
    keys[9] = 1'b0;
    wait_flag(1, 1'b1);
  endtask
  task no_code;
    {shift_key, control_key} = 2'h3;
    repeat (1600) @(negedge mclk);
    check_flag(key_ready_n, 1'b1);
    keys[0] = 1'b1;
    repeat (1600) @(negedge mclk);
    check_flag(key_ready_n, 1'b1);
    keys[0] = 1'b0;
    {shift_key, control_key} = 2'h0;
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    check_code(bus_oe, 8'h00);
    key_case(56, 0, 0, 0, 8'h80);
    key_case(87, 0, 1, 0, 8'h9f);
    key_case(16, 0, 0, 0, 8'h60);
    key_case(16, 0, 1, 0, 8'h40);
    key_case(24, 0, 0, 1, 8'h48);
    key_case(24, 1, 1, 1, 8'h08);
    key_case(50, 0, 0, 0, 8'h0a);
    key_case(1, 0, 1, 0, 8'h21);
    key_case(16, 0, 0, 1, 8'h60);
    bounce;
    lockout;
    no_code;
    conclude;
  end
  initial begin #2000000; errors++; conclude; end
endmodule // test_keyboard_matrix_encoder
